// ==== src/ptm_timer.sv ====
// periodic timer with compare, pwm, single pulse, capture and timer modes
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ptm_timer #(
   parameter int CNT_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire ptm_pkg::ptm_axi_req_t axi_req,
   output var ptm_pkg::ptm_axi_rsp_t axi_rsp,
   input wire logic external_trigger_pin,
   input wire logic timer_io_pin_in,
   output logic timer_io_pin_out,
   output logic timer_io_pin_oe
);

   // only the two documented counter widths are served
   generate
      if (!(CNT_W == 10 || CNT_W == 16))
      begin : g_bad_width
         $error("ptm_timer: CNT_W must be 10 or 16");
      end
   endgenerate

   // merge write data into a word under byte strobes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction

   // mapped register addresses
   function automatic logic addr_ok(input logic [7:0] a);
      return a == ptm_pkg::PTM_CTRL_ADDR || a == ptm_pkg::PTM_DUTY_ADDR || a == ptm_pkg::PTM_PERIOD_ADDR
         || a == ptm_pkg::PTM_COUNT_ADDR || a == ptm_pkg::PTM_FLAGS_ADDR;
   endfunction

   ptm_pkg::ptm_ctrl_t ctrl_reg;
   logic [CNT_W-1:0] duty_reg;
   logic [CNT_W-1:0] period_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [1:0] flags_reg;
   logic en_prev_reg;
   logic trig_prev_reg;
   logic cap_prev_reg;
   logic lvl_reg;
   logic lvl_next;
   logic io_out_reg;
   logic io_oe_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // --------------------------------------------------------------
   // axi4-lite write channel
   // --------------------------------------------------------------

   logic do_wr;
   logic [31:0] ctrl_wr;
   logic [31:0] duty_wr;
   logic [31:0] period_wr;
   logic [31:0] flags_wr;
   assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
   assign ctrl_wr = wmerge(32'(ctrl_reg), wdata_reg, wstrb_reg);
   assign duty_wr = wmerge(32'(duty_reg), wdata_reg, wstrb_reg);
   assign period_wr = wmerge(32'(period_reg), wdata_reg, wstrb_reg);
   assign flags_wr = wmerge(32'h0, wdata_reg, wstrb_reg);

   // address and data are taken in either order and held until the response
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= ptm_pkg::PTM_RESP_OKAY;
      end
      else
      begin
         if (axi_req.awvalid && awready_reg)
         begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= axi_req.awaddr;
            awready_reg <= 1'b0;
         end
         if (axi_req.wvalid && wready_reg)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= axi_req.wdata;
            wstrb_reg <= axi_req.wstrb;
            wready_reg <= 1'b0;
         end
         if (do_wr)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_ok(awaddr_reg) ? ptm_pkg::PTM_RESP_OKAY : ptm_pkg::PTM_RESP_SLVERR;
         end
         if (bvalid_reg && axi_req.bready)
         begin
            bvalid_reg <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // axi4-lite read channel
   // --------------------------------------------------------------

   // one read at a time; data is sampled at the address handshake
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= ptm_pkg::PTM_RESP_OKAY;
      end
      else if (axi_req.arvalid && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= addr_ok(axi_req.araddr) ? ptm_pkg::PTM_RESP_OKAY : ptm_pkg::PTM_RESP_SLVERR;
         case (axi_req.araddr)
            ptm_pkg::PTM_CTRL_ADDR: rdata_reg <= 32'(ctrl_reg);
            ptm_pkg::PTM_DUTY_ADDR: rdata_reg <= 32'(duty_reg);
            ptm_pkg::PTM_PERIOD_ADDR: rdata_reg <= 32'(period_reg);
            ptm_pkg::PTM_COUNT_ADDR: rdata_reg <= 32'(cnt_reg);
            ptm_pkg::PTM_FLAGS_ADDR: rdata_reg <= 32'(flags_reg);
            default: rdata_reg <= 32'h0;
         endcase
      end
      else if (rvalid_reg && axi_req.rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   assign axi_rsp = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg, bresp: bresp_reg,
      arready: arready_reg, rvalid: rvalid_reg, rdata: rdata_reg, rresp: rresp_reg};

   // --------------------------------------------------------------
   // counter and comparators
   // --------------------------------------------------------------

   logic [1:0] mode;
   logic [1:0] act;
   logic cmp_like;
   logic single;
   logic en_rise;
   logic run;
   logic [CNT_W-1:0] cnt_inc;
   logic hit_d;
   logic hit_p;
   logic duty_ev;
   logic period_ev;
   logic cnt_clr;
   logic trig_ev;
   logic cap_pin;
   logic cap_ev;
   logic full_duty;
   assign mode = ctrl_reg.mode_select;
   assign act = ctrl_reg.output_action;
   assign cmp_like = mode == ptm_pkg::PTM_MODE_CMP || mode == ptm_pkg::PTM_MODE_TMR;
   assign single = mode == ptm_pkg::PTM_MODE_PWM && act == ptm_pkg::PTM_ACT_11;
   assign en_rise = ctrl_reg.timer_enable && !en_prev_reg;
   assign run = ctrl_reg.timer_enable && !en_rise;
   // wrapping increment doubles as overflow at the counter maximum
   assign cnt_inc = cnt_reg + 1'b1;
   assign hit_d = cnt_inc == duty_reg && duty_reg != '0;
   // a zero period matches on the wrap, so it acts as the overflow clear
   assign hit_p = cnt_inc == period_reg;
   assign duty_ev = run && hit_d && mode != ptm_pkg::PTM_MODE_CAP;
   assign period_ev = run && hit_p && !single && !(cmp_like && ctrl_reg.clear_select);
   // pwm ignores clear_select; single pulse never clears on a match
   assign cnt_clr = single ? 1'b0 : (cmp_like && ctrl_reg.clear_select) ? hit_d : hit_p;
   assign cnt_next = en_rise ? '0 : !run ? cnt_reg : cnt_clr ? '0 : cnt_inc;
   assign trig_ev = single && external_trigger_pin && !trig_prev_reg;
   assign cap_pin = ctrl_reg.capture_source_select ? external_trigger_pin : timer_io_pin_in;
   // capture edge choice: 00 rising, 01 falling, 10 both, 11 none
   always_comb
   begin
      case (act)
         ptm_pkg::PTM_ACT_00: cap_ev = cap_pin && !cap_prev_reg;
         ptm_pkg::PTM_ACT_01: cap_ev = !cap_pin && cap_prev_reg;
         ptm_pkg::PTM_ACT_10: cap_ev = cap_pin != cap_prev_reg;
         default: cap_ev = 1'b0;
      endcase
      cap_ev = cap_ev && run && mode == ptm_pkg::PTM_MODE_CAP;
   end
   assign full_duty = period_reg != '0 && duty_reg >= period_reg;

   // counter register and edge history; pins are taken as synchronous
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         en_prev_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
         cap_prev_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         en_prev_reg <= ctrl_reg.timer_enable;
         trig_prev_reg <= external_trigger_pin;
         cap_prev_reg <= cap_pin;
      end
   end

   // --------------------------------------------------------------
   // software registers
   // --------------------------------------------------------------

   // hardware enable changes win over a software write in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_reg <= ptm_pkg::PTM_CTRL_RESET;
      else
      begin
         if (do_wr && awaddr_reg == ptm_pkg::PTM_CTRL_ADDR)
            ctrl_reg <= ptm_pkg::ptm_ctrl_t'(ctrl_wr[8:0]);
         if (single && duty_ev)
            ctrl_reg.timer_enable <= 1'b0;
         if (trig_ev)
            ctrl_reg.timer_enable <= 1'b1;
      end
   end

   // a capture overrides a software write to the duty value
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         duty_reg <= CNT_W'(ptm_pkg::PTM_CMP_RESET);
         period_reg <= CNT_W'(ptm_pkg::PTM_CMP_RESET);
      end
      else
      begin
         if (do_wr && awaddr_reg == ptm_pkg::PTM_DUTY_ADDR)
            duty_reg <= duty_wr[CNT_W-1:0];
         if (cap_ev)
            duty_reg <= cnt_reg;
         if (do_wr && awaddr_reg == ptm_pkg::PTM_PERIOD_ADDR)
            period_reg <= period_wr[CNT_W-1:0];
      end
   end

   // sticky flags: write one to clear, a new match wins over the clear
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_reg <= 2'h0;
      else
      begin
         if (do_wr && awaddr_reg == ptm_pkg::PTM_FLAGS_ADDR)
            flags_reg <= flags_reg & ~flags_wr[1:0];
         if (duty_ev || cap_ev)
            flags_reg[ptm_pkg::PTM_DUTY_FLAG_BIT] <= 1'b1;
         if (period_ev)
            flags_reg[ptm_pkg::PTM_PERIOD_FLAG_BIT] <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // output pin
   // --------------------------------------------------------------

   // level before polarity; pwm looks at the next count so pin and counter agree
   always_comb
   begin
      lvl_next = lvl_reg;
      case (mode)
         ptm_pkg::PTM_MODE_CMP:
         begin
            if (en_rise)
               lvl_next = ctrl_reg.output_control;
            else if (duty_ev)
            begin
               case (act)
                  ptm_pkg::PTM_ACT_01: lvl_next = 1'b0;
                  ptm_pkg::PTM_ACT_10: lvl_next = 1'b1;
                  ptm_pkg::PTM_ACT_11: lvl_next = !lvl_reg;
                  default: lvl_next = lvl_reg;
               endcase
            end
         end
         ptm_pkg::PTM_MODE_PWM:
         begin
            case (act)
               ptm_pkg::PTM_ACT_00: lvl_next = !ctrl_reg.output_control;
               ptm_pkg::PTM_ACT_01: lvl_next = ctrl_reg.output_control;
               ptm_pkg::PTM_ACT_10: lvl_next = (ctrl_reg.timer_enable && (full_duty || cnt_next < duty_reg))
                  ? ctrl_reg.output_control : !ctrl_reg.output_control;
               default: lvl_next = (ctrl_reg.timer_enable && !(single && duty_ev) && !trig_ev) || trig_ev
                  ? ctrl_reg.output_control : !ctrl_reg.output_control;
            endcase
         end
         default: lvl_next = lvl_reg;
      endcase
   end

   // pin driven only in compare and pwm modes
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lvl_reg <= 1'b0;
         io_out_reg <= 1'b0;
         io_oe_reg <= 1'b0;
      end
      else
      begin
         lvl_reg <= lvl_next;
         io_out_reg <= lvl_next ^ ctrl_reg.output_polarity;
         io_oe_reg <= mode == ptm_pkg::PTM_MODE_CMP || mode == ptm_pkg::PTM_MODE_PWM;
      end
   end

   assign timer_io_pin_out = io_out_reg;
   assign timer_io_pin_oe = io_oe_reg;

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   duty_flag_a: assert property (duty_ev |=> flags_reg[0]) else $error("duty flag missed");
   // watches the stored flag, so a leak through any path is caught
   no_pflag_a: assert property (cmp_like && ctrl_reg.clear_select && !flags_reg[1] |=> !flags_reg[1])
      else $error("period flag with clear_select high");
   timer_pin_a: assert property (
      mode == ptm_pkg::PTM_MODE_TMR ##1 mode == ptm_pkg::PTM_MODE_TMR |-> !timer_io_pin_oe)
      else $error("pin driven in timer mode");
   init_level_a: assert property (en_rise && mode == ptm_pkg::PTM_MODE_CMP
      |=> timer_io_pin_out == ($past(ctrl_reg.output_control) ^ $past(ctrl_reg.output_polarity)))
      else $error("initial level not loaded");
   pulse_end_a: assert property (single && duty_ev && !trig_ev |=> !ctrl_reg.timer_enable)
      else $error("pulse not ended by duty match");
   cnt_restart_a: assert property (en_rise |=> cnt_reg == '0) else $error("counter not zeroed");
   capture_a: assert property (cap_ev |=> duty_reg == $past(cnt_reg) && flags_reg[0])
      else $error("capture value wrong");
   period_clr_a: assert property (
      run && !single && mode == ptm_pkg::PTM_MODE_PWM && hit_p |=> cnt_reg == '0)
      else $error("pwm period clear missed");
   full_duty_a: assert property (
      mode == ptm_pkg::PTM_MODE_PWM && act == ptm_pkg::PTM_ACT_10 && run && full_duty
      |=> timer_io_pin_out == ($past(ctrl_reg.output_control) ^ $past(ctrl_reg.output_polarity)))
      else $error("full duty not active");

endmodule
`default_nettype wire

// ==== src/ptm_pkg.sv ====
// package: register map, field layout and bus carriers of the periodic timer
package ptm_pkg;
   // register byte addresses
   localparam logic [7:0] PTM_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PTM_DUTY_ADDR = 8'h04;
   localparam logic [7:0] PTM_PERIOD_ADDR = 8'h08;
   localparam logic [7:0] PTM_COUNT_ADDR = 8'h0c;
   localparam logic [7:0] PTM_FLAGS_ADDR = 8'h10;
   // flag positions in the flags word
   localparam int PTM_DUTY_FLAG_BIT = 0;
   localparam int PTM_PERIOD_FLAG_BIT = 1;
   // mode_select codes
   localparam logic [1:0] PTM_MODE_CMP = 2'h0;
   localparam logic [1:0] PTM_MODE_CAP = 2'h1;
   localparam logic [1:0] PTM_MODE_PWM = 2'h2;
   localparam logic [1:0] PTM_MODE_TMR = 2'h3;
   // output_action codes
   localparam logic [1:0] PTM_ACT_00 = 2'h0;
   localparam logic [1:0] PTM_ACT_01 = 2'h1;
   localparam logic [1:0] PTM_ACT_10 = 2'h2;
   localparam logic [1:0] PTM_ACT_11 = 2'h3;
   // axi responses
   localparam logic [1:0] PTM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PTM_RESP_SLVERR = 2'h2;
   // reset values
   localparam logic [8:0] PTM_CTRL_RESET = 9'h000;
   localparam logic [15:0] PTM_CMP_RESET = 16'h0000;

   // control word, bit 8 down to bit 0
   typedef struct packed {
      logic timer_enable;
      logic [1:0] mode_select;
      logic [1:0] output_action;
      logic output_control;
      logic output_polarity;
      logic capture_source_select;
      logic clear_select;
   } ptm_ctrl_t;

   // master to slave
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } ptm_axi_req_t;

   // slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ptm_axi_rsp_t;
endpackage

// ==== verification/ptm_pin_model.sv ====
// partner model: shared io pin level and external trigger source
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_model (
   input wire logic sys_clk,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_in,
   output var logic trig
);
   // a released pin floats to its pull-up level, never the last driven value
   assign pin_in = pin_oe ? pin_out : 1'b1;

   // trigger idles low
   initial trig = 1'b0;

   // pulse held three clocks, longer than the one-clock capture minimum
   task automatic fire();
      @(posedge sys_clk);
      trig <= 1'b1;
      repeat (3) @(posedge sys_clk);
      trig <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// testbench: register bus tests across all timer modes
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   ptm_pkg::ptm_axi_req_t req = '0;
   ptm_pkg::ptm_axi_rsp_t rsp;
   logic pin_out;
   logic pin_oe;
   logic pin_in;
   logic trig;
   logic [31:0] rd;
   logic [1:0] resp;
   int n_fail = 0;
   int comparisons = 0;
   int h;
   // pwm table: control byte, duty, period, expected active clocks per period, expected flags
   int pw_ctl[7] = '{8'ha8, 8'ha8, 8'hac, 8'h88, 8'h98, 8'ha0, 8'ha8};
   int pw_duty[7] = '{3, 9, 3, 3, 3, 3, 512};
   int pw_per[7] = '{8, 8, 8, 8, 8, 8, 0};
   int pw_exp[7] = '{3, 8, 5, 0, 8, 5, 512};
   // duty above period is never reached by the counter, so no duty flag there
   int pw_flg[7] = '{3, 2, 3, 3, 3, 3, 3};

   always #10 sys_clk = ~sys_clk;

   ptm_timer #(.CNT_W(10)) u_ptm_timer (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
      .external_trigger_pin(trig), .timer_io_pin_in(pin_in), .timer_io_pin_out(pin_out),
      .timer_io_pin_oe(pin_oe));
   ptm_pin_model u_ptm_pin_model (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
      .trig(trig));

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (rsp.awready === 1'b1)
            req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1)
            req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      resp = rsp.bresp;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (rsp.arready === 1'b1)
            req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      d = rsp.rdata;
      resp = rsp.rresp;
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      chk(what, exp, d);
   endtask

   // enable goes low first so the final write is a true rising edge
   task automatic start(input logic [7:0] c, input logic en, input logic [31:0] duty, input logic [31:0] per);
      wr(ptm_pkg::PTM_CTRL_ADDR, {24'h0, c});
      wr(ptm_pkg::PTM_DUTY_ADDR, duty);
      wr(ptm_pkg::PTM_PERIOD_ADDR, per);
      wr(ptm_pkg::PTM_FLAGS_ADDR, 32'h3);
      wr(ptm_pkg::PTM_CTRL_ADDR, {23'h0, en, c});
   endtask

   // active clocks of the pin over a window
   task automatic hi(input int n);
      h = 0;
      repeat (n)
      begin
         @(posedge sys_clk);
         if (pin_out === 1'b1)
            h++;
      end
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk("ctrl reset", ptm_pkg::PTM_CTRL_ADDR, 32'h0);
      rchk("period reset", ptm_pkg::PTM_PERIOD_ADDR, 32'h0);
      rchk("flags reset", ptm_pkg::PTM_FLAGS_ADDR, 32'h0);
      rd_reg(8'h14, rd);
      chk("unmapped read", {30'h0, ptm_pkg::PTM_RESP_SLVERR}, {30'h0, resp});
      chk("unmapped data", 32'h0, rd);
      wr(8'h14, 32'h1);
      chk("unmapped write", {30'h0, ptm_pkg::PTM_RESP_SLVERR}, {30'h0, resp});
      wr(ptm_pkg::PTM_PERIOD_ADDR, 32'hffffffff);
      rchk("period width", ptm_pkg::PTM_PERIOD_ADDR, 32'h3ff);
      $display("test registers done");
      // compare mode, initial high, one duty match per action code
      for (int i = 0; i < 4; i++)
      begin
         start({2'b00, i[1:0], 4'b1000}, 1'b1, 32'd20, 32'd1000);
         repeat (3) @(posedge sys_clk);
         chk1("pin initial", 1'b1, pin_out);
         chk1("pin driven", 1'b1, pin_oe);
         repeat (40) @(posedge sys_clk);
         // codes 00 none and 10 high leave the pin high, 01 low and 11 toggle bring it low
         chk1("pin on match", !i[0], pin_out);
         rchk("cmp flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h1);
      end
      start(8'h00, 1'b1, 32'd4, 32'd10);
      repeat (30) @(posedge sys_clk);
      rchk("period clear flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h3);
      rd_reg(ptm_pkg::PTM_COUNT_ADDR, rd);
      chk1("count below period", 1'b1, rd < 10);
      start(8'h01, 1'b1, 32'd5, 32'd3);
      repeat (30) @(posedge sys_clk);
      rchk("duty clear flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h1);
      rd_reg(ptm_pkg::PTM_COUNT_ADDR, rd);
      chk1("count below duty", 1'b1, rd < 5);
      start(8'hc0, 1'b1, 32'd0, 32'd0);
      repeat (1100) @(posedge sys_clk);
      rchk("wrap flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h2);
      chk1("timer pin free", 1'b0, pin_oe);
      $display("test compare done");
      // pwm waveforms measured over one whole period in steady state
      for (int i = 0; i < 7; i++)
      begin
         start(pw_ctl[i][7:0], 1'b1, pw_duty[i], pw_per[i]);
         repeat (20) @(posedge sys_clk);
         hi((pw_per[i] == 0) ? 1024 : pw_per[i]);
         chk("pwm active clocks", pw_exp[i], h);
         rchk("pwm flags", ptm_pkg::PTM_FLAGS_ADDR, pw_flg[i]);
      end
      $display("test pwm done");
      // single pulse started by the trigger pin, stopped by the duty match
      start(8'hb8, 1'b0, 32'd6, 32'd0);
      fork
         u_ptm_pin_model.fire();
         hi(40);
      join
      // one clock for the trigger edge, then six counts up to the duty value
      chk("pulse width", 32'h7, h);
      rchk("pulse enable cleared", ptm_pkg::PTM_CTRL_ADDR, 32'hb8);
      rchk("pulse flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h1);
      $display("test pulse done");
      // capture from the trigger pin on rising, then both edges, then switched off
      // trigger rises at count 11 and falls at count 14 after the enable write
      start(8'h42, 1'b1, 32'd0, 32'd0);
      repeat (10) @(posedge sys_clk);
      u_ptm_pin_model.fire();
      repeat (5) @(posedge sys_clk);
      rchk("capture flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h1);
      rchk("captured count", ptm_pkg::PTM_DUTY_ADDR, 32'hb);
      start(8'h62, 1'b1, 32'd0, 32'd0);
      repeat (10) @(posedge sys_clk);
      u_ptm_pin_model.fire();
      repeat (5) @(posedge sys_clk);
      rchk("both edge count", ptm_pkg::PTM_DUTY_ADDR, 32'he);
      start(8'h72, 1'b1, 32'd0, 32'd0);
      repeat (10) @(posedge sys_clk);
      u_ptm_pin_model.fire();
      repeat (5) @(posedge sys_clk);
      rchk("capture off flags", ptm_pkg::PTM_FLAGS_ADDR, 32'h0);
      $display("test capture done");
      close_out();
   end

   // watchdog well beyond the few thousand clocks the tests need
   initial
   begin
      #600000;
      n_fail++;
      close_out();
   end
endmodule
`default_nettype wire
